// [logic/scs_pkg.sv]
/*
 * serial control/status package: register offsets, field positions,
 * reset values and the shared state types of the serial control block.
 * assumes a byte-wide register port with a four-bit word address.
 */
`default_nettype none

package scs_pkg;

	// ==========================================================
	// register map
	localparam logic [3:0] SCS_ADDR_CTRL = 4'h0;   // serial_iface_control_status
	localparam logic [3:0] SCS_ADDR_DATA = 4'h1;   // serial_data_reg
	localparam logic [3:0] SCS_ADDR_CFG = 4'h2;    // master_enable
	localparam logic [3:0] SCS_ADDR_ISTS = 4'h3;   // sticky event status, write one to clear
	localparam logic [3:0] SCS_ADDR_IMASK = 4'h4;  // event mask

	// ==========================================================
	// control/status field positions
	localparam int SCS_BIT_DONE = 7;
	localparam int SCS_BIT_COLL = 6;
	localparam int SCS_BIT_FAULT = 5;
	localparam int SCS_BIT_OVR = 4;
	localparam int SCS_BIT_MODE_HI = 3;
	localparam int SCS_BIT_MODE_LO = 2;
	localparam int SCS_BIT_TXEMPTY = 1;
	localparam int SCS_BIT_EN = 0;
	localparam int SCS_BIT_MASTER = 0;

	// ==========================================================
	// reset values and modes
	localparam logic [7:0] SCS_CTRL_RESET = 8'h06;
	localparam logic [1:0] SCS_MODE_3WIRE = 2'h0;
	localparam logic [1:0] SCS_MODE_4WIRE_IN = 2'h1;
	localparam logic [1:0] SCS_MODE_RESET = 2'h1;
	localparam logic [3:0] SCS_IMASK_RESET = 4'h0;
	localparam logic [2:0] SCS_LAST_BIT = 3'h7;
	localparam logic [7:0] SCS_BYTE_ZERO = 8'h00;

	// shift engine states, one-hot
	typedef enum logic [1:0] {
		SCS_IDLE = 2'b01,
		SCS_SHIFT = 2'b10
	} scs_state_t;

	// all state of the control block except txbuf and the synchroniser flops
	typedef struct packed {
		scs_state_t st;
		logic [2:0] bitcnt;
		logic [7:0] shin;
		logic [7:0] shout;
		logic sck_prev;
		logic done;
		logic wr_coll;
		logic mode_fault;
		logic ovr;
		logic [1:0] ssmode;
		logic tx_empty;
		logic en;
		logic master_en;
		logic [7:0] rxbuf;
		logic rxfull;
		logic [3:0] ists;
		logic [3:0] imask;
		logic [7:0] rdata;
		logic irq;
		logic sdo;
		logic sdo_oe;
		logic ss_out;
		logic ss_oe;
	} scs_regs_t;

	// event vector order: done, collision, mode fault, overrun
	function automatic logic [3:0] scs_events(input logic d, input logic w, input logic m, input logic o);
		scs_events = {d, w, m, o};
	endfunction : scs_events

endpackage : scs_pkg

`default_nettype wire

// [logic/scs_sync.sv]
/*
 * two flip-flop synchroniser for a bundle of unrelated levels.
 * assumes each bit is an independent slow level; no bus coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : scs_sync

`default_nettype wire

// [logic/scs_byte_buf.sv]
/*
 * one-byte transmit holding buffer with registered read data.
 * assumes the writer only writes when the buffer may be overwritten.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_byte_buf
	import scs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// write side
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// read side
	output logic [7:0] rd_data
);

	// contents come straight out of the storage flop
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= SCS_BYTE_ZERO;
		end else if (wr_en) begin
			rd_data <= wr_data;
		end
	end

endmodule : scs_byte_buf

`default_nettype wire

// [logic/scs_ctrl.sv]
/*
 * control and status logic of the byte serial interface, with a small
 * shift engine that turns link clock edges into transfer events.
 * assumes the serial clock always comes from the far side and is much
 * slower than ref_clk; the register master never overlaps strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_ctrl
	import scs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// interrupt
	output logic irq,
	// serial link
	input wire logic sck_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe,
	// slave select pin, active low
	input wire logic slave_select_pin_n_in,
	output logic slave_select_pin_n_out,
	output logic slave_select_pin_n_oe
);

	// ==========================================================
	// synchronised link inputs
	logic [2:0] pins_s;
	logic sck_s;
	logic sdi_s;
	logic ss_n_s;

	scs_sync #(
		.WIDTH(3)
	) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in({sck_in, sdi_in, slave_select_pin_n_in}),
		.sync_out(pins_s)
	);

	assign sck_s = pins_s[2];
	assign sdi_s = pins_s[1];
	assign ss_n_s = pins_s[0];

	// ==========================================================
	// state and decode
	scs_regs_t q;
	scs_regs_t next_q;
	logic [7:0] txbuf;
	logic wr_ctrl;
	logic wr_data;
	logic wr_cfg;
	logic wr_ists;
	logic wr_imask;
	logic rd_data;
	logic tx_accept;
	logic sck_rise;
	logic sck_fall;
	logic selected;
	logic ev_done;
	logic ev_coll;
	logic ev_fault;
	logic ev_ovr;
	logic [7:0] rx_byte;
	logic [3:0] ev_vec;

	// strobes qualified by address
	assign wr_ctrl = reg_wr && (reg_addr == SCS_ADDR_CTRL);
	assign wr_data = reg_wr && (reg_addr == SCS_ADDR_DATA);
	assign wr_cfg = reg_wr && (reg_addr == SCS_ADDR_CFG);
	assign wr_ists = reg_wr && (reg_addr == SCS_ADDR_ISTS);
	assign wr_imask = reg_wr && (reg_addr == SCS_ADDR_IMASK);
	assign rd_data = reg_rd && (reg_addr == SCS_ADDR_DATA);
	assign tx_accept = wr_data && q.tx_empty;

	// link clock edges from the synchronised copy and its delayed twin
	assign sck_rise = sck_s && !q.sck_prev;
	assign sck_fall = !sck_s && q.sck_prev;

	// who may clock bytes in; mode 00 never looks at the pin
	assign selected = q.en && ((q.ssmode == SCS_MODE_3WIRE) || q.ssmode[1] ||
		((q.ssmode == SCS_MODE_4WIRE_IN) && !ss_n_s && !q.master_en));

	assign rx_byte = {q.shin[6:0], sdi_s};
	assign ev_done = (q.st == SCS_SHIFT) && selected && sck_rise && (q.bitcnt == SCS_LAST_BIT);
	assign ev_coll = wr_data && !q.tx_empty;
	assign ev_fault = q.en && q.master_en && (q.ssmode == SCS_MODE_4WIRE_IN) && !ss_n_s;
	assign ev_ovr = ev_done && q.rxfull && !q.master_en;
	assign ev_vec = scs_events(ev_done, ev_coll, ev_fault, ev_ovr);

	// transmit holding byte; a refused write never reaches it
	scs_byte_buf u_txbuf (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.wr_en(tx_accept),
		.wr_data(reg_wdata),
		.rd_data(txbuf)
	);

	// ==========================================================
	// next state
	always_comb begin
		next_q = q;
		next_q.sck_prev = sck_s;

		// control/status write: flags store the written bit, empty flag untouched
		if (wr_ctrl) begin
			next_q.done = reg_wdata[SCS_BIT_DONE];
			next_q.wr_coll = reg_wdata[SCS_BIT_COLL];
			next_q.mode_fault = reg_wdata[SCS_BIT_FAULT];
			next_q.ovr = reg_wdata[SCS_BIT_OVR];
			next_q.ssmode = reg_wdata[SCS_BIT_MODE_HI:SCS_BIT_MODE_LO];
			next_q.en = reg_wdata[SCS_BIT_EN];
		end
		if (wr_cfg) begin
			next_q.master_en = reg_wdata[SCS_BIT_MASTER];
		end
		if (wr_imask) begin
			next_q.imask = reg_wdata[3:0];
		end

		// reading the data register frees the receive buffer
		if (rd_data) begin
			next_q.rxfull = 1'b0;
		end

		// shift engine
		case (q.st)
			SCS_IDLE: begin
				if (!q.tx_empty) begin
					next_q.shout = txbuf;
					next_q.tx_empty = 1'b1;
				end
				if (selected && sck_rise) begin
					next_q.shin = rx_byte;
					next_q.bitcnt = 3'h1;
					next_q.st = SCS_SHIFT;
				end
			end
			SCS_SHIFT: begin
				if (sck_fall) begin
					next_q.shout = {q.shout[6:0], 1'b0};
				end
				if (sck_rise) begin
					next_q.shin = rx_byte;
					next_q.bitcnt = q.bitcnt + 3'h1;
				end
				if (ev_done) begin
					next_q.st = SCS_IDLE;
					next_q.bitcnt = 3'h0;
					// an unread byte is kept unless master_en is set; the new one is lost on overrun
					if (!ev_ovr) begin
						next_q.rxbuf = rx_byte;
						next_q.rxfull = 1'b1;
					end
				end
				// dropping select or enable abandons the byte in flight
				if (!selected) begin
					next_q.st = SCS_IDLE;
					next_q.bitcnt = 3'h0;
				end
			end
			default: begin
				next_q.st = SCS_IDLE;
				next_q.bitcnt = 3'h0;
			end
		endcase

		// events win over a clear in the same cycle
		next_q.done = next_q.done | ev_done;
		next_q.wr_coll = next_q.wr_coll | ev_coll;
		next_q.mode_fault = next_q.mode_fault | ev_fault;
		next_q.ovr = next_q.ovr | ev_ovr;

		// accepted data write fills the buffer
		if (tx_accept) begin
			next_q.tx_empty = 1'b0;
		end

		// interrupt status, write one to clear, set wins
		next_q.ists = (q.ists & ~(wr_ists ? reg_wdata[3:0] : 4'h0)) | ev_vec;
		next_q.irq = |(next_q.ists & next_q.imask);

		// link outputs
		next_q.sdo = next_q.shout[7];
		next_q.sdo_oe = q.en && (q.master_en || selected);
		next_q.ss_oe = next_q.ssmode[1];
		next_q.ss_out = next_q.ssmode[0];

		// read data, valid the cycle after the strobe only
		next_q.rdata = SCS_BYTE_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				SCS_ADDR_CTRL: next_q.rdata = {q.done, q.wr_coll, q.mode_fault, q.ovr, q.ssmode, q.tx_empty, q.en};
				SCS_ADDR_DATA: next_q.rdata = q.rxbuf;
				SCS_ADDR_CFG: next_q.rdata = {7'h00, q.master_en};
				SCS_ADDR_ISTS: next_q.rdata = {4'h0, q.ists};
				SCS_ADDR_IMASK: next_q.rdata = {4'h0, q.imask};
				default: next_q.rdata = SCS_BYTE_ZERO;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= SCS_IDLE;
			q.ssmode <= SCS_MODE_RESET;
			q.tx_empty <= SCS_CTRL_RESET[SCS_BIT_TXEMPTY];
			q.en <= SCS_CTRL_RESET[SCS_BIT_EN];
			q.imask <= SCS_IMASK_RESET;
		end else begin
			q <= next_q;
		end
	end

	// outputs straight from flops
	assign reg_rdata = q.rdata;
	assign irq = q.irq;
	assign sdo_out = q.sdo;
	assign sdo_oe = q.sdo_oe;
	assign slave_select_pin_n_out = q.ss_out;
	assign slave_select_pin_n_oe = q.ss_oe;

	// ==========================================================
	// checks
	sequence s_load;
		(q.st == SCS_IDLE) && !q.tx_empty;
	endsequence

	sequence s_loaded;
		q.tx_empty && (q.shout == $past(txbuf));
	endsequence

	property p_done_set;
		@(posedge ref_clk) disable iff (sys_rst) ev_done |=> q.done;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set after transfer");

	property p_flag_hold;
		@(posedge ref_clk) disable iff (sys_rst) (q.done && !wr_ctrl) |=> q.done;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("done flag cleared without software");

	property p_fault_hold;
		@(posedge ref_clk) disable iff (sys_rst) (q.mode_fault && !wr_ctrl) |=> q.mode_fault;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("mode fault cleared by hardware");

	// an event seen through an open mask must reach the pin one cycle later
	property p_irq;
		@(posedge ref_clk) disable iff (sys_rst) ((|(ev_vec & q.imask)) && !wr_imask) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled event without interrupt");

	property p_coll;
		@(posedge ref_clk) disable iff (sys_rst) (wr_data && !q.tx_empty) |=> (q.wr_coll && $stable(txbuf));
	endproperty
	a_coll: assert property (p_coll) else $error("collision not flagged or buffer changed");

	property p_fault;
		@(posedge ref_clk) disable iff (sys_rst)
			(q.en && q.master_en && (q.ssmode == SCS_MODE_4WIRE_IN) && !ss_n_s) |=> q.mode_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not flagged");

	property p_ovr_master;
		@(posedge ref_clk) disable iff (sys_rst) (q.master_en && !q.ovr && !wr_ctrl) |=> !q.ovr;
	endproperty
	a_ovr_master: assert property (p_ovr_master) else $error("overrun set in master operation");

	// judged from the write itself, so a mode change in the same cycle is not blamed
	property p_three_wire;
		@(posedge ref_clk) disable iff (sys_rst)
			(wr_ctrl && (reg_wdata[SCS_BIT_MODE_HI:SCS_BIT_MODE_LO] == SCS_MODE_3WIRE))
			|=> !slave_select_pin_n_oe;
	endproperty
	a_three_wire: assert property (p_three_wire) else $error("select pin driven in three-wire mode");

	property p_no_pin;
		@(posedge ref_clk) disable iff (sys_rst)
			(q.en && (q.ssmode == SCS_MODE_3WIRE) && (q.st == SCS_IDLE) && sck_rise) |=> (q.st == SCS_SHIFT);
	endproperty
	a_no_pin: assert property (p_no_pin) else $error("three-wire byte did not start");

	property p_ss_input;
		@(posedge ref_clk) disable iff (sys_rst)
			((q.ssmode == SCS_MODE_4WIRE_IN) && ss_n_s && (q.st == SCS_IDLE)) |=> (q.st == SCS_IDLE);
	endproperty
	a_ss_input: assert property (p_ss_input) else $error("transfer started while deselected");

	property p_ss_out;
		@(posedge ref_clk) disable iff (sys_rst) (wr_ctrl && reg_wdata[SCS_BIT_MODE_HI]) |=>
			(slave_select_pin_n_oe && (slave_select_pin_n_out == $past(reg_wdata[SCS_BIT_MODE_LO])));
	endproperty
	a_ss_out: assert property (p_ss_out) else $error("select pin not driven with mode bit");

	property p_empty_clr;
		@(posedge ref_clk) disable iff (sys_rst) tx_accept |=> !q.tx_empty;
	endproperty
	a_empty_clr: assert property (p_empty_clr) else $error("buffer-empty not cleared by write");

	property p_empty_set;
		@(posedge ref_clk) disable iff (sys_rst) s_load |=> s_loaded;
	endproperty
	a_empty_set: assert property (p_empty_set) else $error("buffer byte not moved to shifter");

	// a control write may re-enable next cycle, so only an untouched disable counts
	property p_disabled;
		@(posedge ref_clk) disable iff (sys_rst) (!q.en && !wr_ctrl) |=> (q.st == SCS_IDLE) [*2];
	endproperty
	a_disabled: assert property (p_disabled) else $error("shifting while disabled");

	property p_empty_ro;
		@(posedge ref_clk) disable iff (sys_rst)
			(wr_ctrl && !reg_wdata[SCS_BIT_TXEMPTY] && q.tx_empty) |=> q.tx_empty;
	endproperty
	a_empty_ro: assert property (p_empty_ro) else $error("buffer-empty bit written by software");

endmodule : scs_ctrl

`default_nettype wire

// [tb/scs_link_model.sv]
/*
 * far-side serial party: makes the link clock, drives serial data
 * and the select pin, and collects the byte coming back.
 * assumes the bench pulls the data wire up and lets the select wire follow ss_n whenever the dut does not drive it.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_link_model (
	// serial wires
	output logic sck,
	output logic sdi,
	output logic ss_n,
	input wire logic sdo_line
);
	logic busy;

	// ==========================================================
	// idle line: the clock stands still, data keeps changing
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		ss_n = 1'b1;
		busy = 1'b0;
	end

	// a stale data level must never look like a valid bit
	always #40 if (!busy) sdi = ~sdi;

	// ==========================================================
	// one byte, msb first, 320 ns clock, data sampled on rising edge
	task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
		busy = 1'b1;
		ss_n = ~sel;
		#200;
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			#160 sck = 1'b1;
			rx = {rx[6:0], sdo_line};
			#160 sck = 1'b0;
		end
		#200 ss_n = 1'b1;
		busy = 1'b0;
		#200;
	endtask : xfer
endmodule : scs_link_model

`default_nettype wire

// [tb/testbench.sv]
/*
 * self-checking bench for the serial control block: register
 * accesses, interrupt masking, link transfers and select pin modes.
 * assumes the link model above, a pull-up on sdo_line and ss_line falling back to the model's select.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import scs_pkg::*;

	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic irq;
	wire logic sck;
	wire logic sdi;
	wire logic ss_drv;
	logic sdo_out;
	logic sdo_oe;
	logic ss_out;
	logic ss_oe;
	wire logic sdo_line;
	wire logic ss_line;
	logic [7:0] rx;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;

	// ==========================================================
	// clock, wires and instances
	always #20 ref_clk = ~ref_clk;

	// sdo_line floats high when nobody drives it; ss_line falls back to the link model's select
	assign sdo_line = sdo_oe ? sdo_out : 1'b1;
	assign ss_line = ss_oe ? ss_out : ss_drv;

	scs_ctrl u_dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.irq(irq),
		.sck_in(sck),
		.sdi_in(sdi),
		.sdo_out(sdo_out),
		.sdo_oe(sdo_oe),
		.slave_select_pin_n_in(ss_line),
		.slave_select_pin_n_out(ss_out),
		.slave_select_pin_n_oe(ss_oe)
	);

	scs_link_model u_link (
		.sck(sck),
		.sdi(sdi),
		.ss_n(ss_drv),
		.sdo_line(sdo_line)
	);

	// ==========================================================
	// report helpers
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	// ==========================================================
	// register port; hold keeps the strobe up for a back-to-back write
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic hold);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		if (!hold) begin
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, exp);
	endtask : rd

	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : pause

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(SCS_ADDR_CTRL, 8'h06);
		rd(SCS_ADDR_IMASK, 8'h00);
		rd(4'h9, 8'h00);
		// buffer-empty ignores writes, mode 00 stored
		wr(SCS_ADDR_CTRL, 8'h01, 1'b0);
		rd(SCS_ADDR_CTRL, 8'h03);
		// single-master modes drive the pin with the low mode bit
		wr(SCS_ADDR_CTRL, 8'h0c, 1'b0);
		pause(2);
		chk({6'h0, ss_oe, ss_out}, 8'h03);
		wr(SCS_ADDR_CTRL, 8'h08, 1'b0);
		pause(2);
		chk({6'h0, ss_oe, ss_out}, 8'h02);
		wr(SCS_ADDR_CTRL, 8'h05, 1'b0);
		pause(2);
		chk({7'h0, ss_oe}, 8'h00);
		// second write lands while the buffer is still full
		wr(SCS_ADDR_DATA, 8'ha5, 1'b1);
		wr(SCS_ADDR_DATA, 8'h3c, 1'b0);
		rd(SCS_ADDR_CTRL, 8'h47);
		u_link.xfer(8'h3c, 1'b1, rx);
		chk(rx, 8'ha5);
		pause(4);
		rd(SCS_ADDR_CTRL, 8'hc7);
		rd(SCS_ADDR_ISTS, 8'h0c);
		chk({7'h0, irq}, 8'h00);
		wr(SCS_ADDR_IMASK, 8'h08, 1'b0);
		pause(2);
		chk({7'h0, irq}, 8'h01);
		rd(SCS_ADDR_DATA, 8'h3c);
		wr(SCS_ADDR_ISTS, 8'h08, 1'b0);
		pause(2);
		chk({7'h0, irq}, 8'h00);
		pause(20);
		rd(SCS_ADDR_CTRL, 8'hc7);
		wr(SCS_ADDR_CTRL, 8'h05, 1'b0);
		rd(SCS_ADDR_CTRL, 8'h07);
		// second byte while the first is unread
		u_link.xfer(8'h11, 1'b1, rx);
		u_link.xfer(8'h22, 1'b1, rx);
		pause(4);
		rd(SCS_ADDR_CTRL, 8'h97);
		rd(SCS_ADDR_DATA, 8'h11);
		// master enabled, mode 01, pin pulled low from outside
		wr(SCS_ADDR_CFG, 8'h01, 1'b0);
		wr(SCS_ADDR_CTRL, 8'h05, 1'b0);
		u_link.xfer(8'h55, 1'b1, rx);
		pause(4);
		rd(SCS_ADDR_CTRL, 8'h27);
		// disabled interface ignores a whole byte
		wr(SCS_ADDR_CFG, 8'h00, 1'b0);
		wr(SCS_ADDR_CTRL, 8'h04, 1'b0);
		u_link.xfer(8'h66, 1'b1, rx);
		pause(4);
		rd(SCS_ADDR_CTRL, 8'h06);
		// three-wire mode takes a byte with the pin left high
		wr(SCS_ADDR_CTRL, 8'h01, 1'b0);
		u_link.xfer(8'h77, 1'b0, rx);
		pause(4);
		rd(SCS_ADDR_CTRL, 8'h83);
		rd(SCS_ADDR_DATA, 8'h77);
		conclude();
	end
endmodule : testbench

`default_nettype wire
